// >>> aqe_consts.svh
// constants for the quadrature encoder interface
// Behaviour
// - a global configuration bit decides whether shared pins act as encoder inputs
// - the null channel is optional; the block works with it unused
// - a valid null event either clears the position or latches it
// - continuous option acts on every null event
// - single option acts on the next null event, then disarms itself
// - A and B qualifier flags demand that the selected channels are high
// - null clears position only with clear flag and single or continuous set
// - each single A or B edge adds or subtracts the constant by direction; simultaneous A and B edges are not counted
// - constant is signed 16.16; binary fraction counts in 2^-16 units
// - decimal mode fraction runs 0 to 9999 and wraps at ten thousand
// - accumulated position is readable by software at any time
// - status records that a null event cleared the position
// - latch mode copies the position into a separate latch register
// - A, B and N pass a spike filter of three clock periods
// - position versus motor position beyond a limit raises step-loss interrupt
`ifndef AQE_CONSTS_SVH
`define AQE_CONSTS_SVH
// register byte offsets
`define AQE_OFS_GLOBAL_CFG 12'h000
`define AQE_OFS_MODE 12'h004
`define AQE_OFS_POS 12'h008
`define AQE_OFS_CONST 12'h00c
`define AQE_OFS_STATUS 12'h010
`define AQE_OFS_LATCH 12'h014
`define AQE_OFS_DEVLIM 12'h018
`define AQE_OFS_MASK 12'h01c
// encoder_mode_config field positions
`define AQE_MODE_POL_A 0
`define AQE_MODE_POL_B 1
`define AQE_MODE_POL_N 2
`define AQE_MODE_CLR_CONT 3
`define AQE_MODE_CLR_ONCE 4
`define AQE_MODE_CLR_ENC 5
`define AQE_MODE_DEC 6
// status and mask field positions
`define AQE_ST_NCLR 0
`define AQE_ST_DEV 1
// reset values
`define AQE_GLOBAL_CFG_RST 1'h0
`define AQE_MODE_RST 7'h04
`define AQE_CONST_RST 32'h00010000
`define AQE_DEVLIM_RST 32'h00000000
// decimal fraction base and filter length
`define AQE_DEC_BASE 17'h02710
`define AQE_FILT_LEN 3
`endif

// >>> aqe_pkg.sv
// types shared by the quadrature encoder interface
package aqe_pkg;
  typedef logic [31:0] aqe_word_type;
  typedef logic [11:0] aqe_addr_type;
  typedef logic [6:0] aqe_mode_type;
  typedef logic [1:0] aqe_stat_type;

  typedef struct packed {
    logic [2:0] sh_a;
    logic [2:0] sh_b;
    logic [2:0] sh_n;
    logic flt_a;
    logic flt_b;
    logic flt_n;
    logic prv_a;
    logic prv_b;
    logic prv_n;
    logic pins_en;
    aqe_mode_type mode;
    aqe_word_type pos;
    logic [15:0] frac;
    aqe_word_type konst;
    aqe_word_type latch;
    aqe_word_type dev_lim;
    aqe_stat_type stat;
    aqe_stat_type mask;
    aqe_word_type rdata;
    logic ready;
    logic slverr;
    logic irq;
  } aqe_state_type;
endpackage

// >>> aqe_encoder.sv
// quadrature encoder interface with apb registers
`include "aqe_consts.svh"

module aqe_encoder
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire aqe_pkg::aqe_addr_type paddr_in,
  input wire aqe_pkg::aqe_word_type pwdata_in,
  output aqe_pkg::aqe_word_type prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // encoder pins and motor position
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  input wire logic enc_n_in,
  input wire aqe_pkg::aqe_word_type motor_pos_in,
  // status
  output logic enc_pins_sel_out,
  output logic irq_out
);
  import aqe_pkg::*;

  aqe_state_type st_r;
  aqe_state_type st_nxt;

  logic setup_ph;
  logic wr_en;
  logic wr_pos;
  logic step_ev;
  logic step_up;
  logic n_edge;
  logic n_qual;
  logic n_valid;
  logic n_armed;
  logic n_clear;
  logic n_latch;
  logic dev_over;
  logic [47:0] stepped;
  aqe_stat_type stat_set;
  aqe_stat_type stat_clr;

  // one fixed-point step of the position, binary or decimal fraction
  function automatic logic [47:0] aqe_step(input aqe_word_type pos, input logic [15:0] frac,
                                           input aqe_word_type k, input logic dec,
                                           input logic up);
    logic [16:0] fs;
    logic cy;
    aqe_word_type ki;
    aqe_word_type np;
    fs = up ? ({1'b0, frac} + {1'b0, k[15:0]}) : ({1'b0, frac} - {1'b0, k[15:0]});
    ki = {{16{k[31]}}, k[31:16]};
    cy = fs[16];
    if (dec)
    begin
      if (up)
      begin
        cy = (fs >= `AQE_DEC_BASE);
        if (cy)
        begin
          fs = fs - `AQE_DEC_BASE;
        end
      end
      else if (cy)
      begin
        fs = fs + `AQE_DEC_BASE;
      end
    end
    if (up)
    begin
      np = pos + ki + {31'h0, cy};
    end
    else
    begin
      np = pos - ki - {31'h0, cy};
    end
    return {np, fs[15:0]};
  endfunction

  // magnitude of the difference of two signed words
  function automatic logic [32:0] aqe_absdiff(input aqe_word_type x, input aqe_word_type y);
    logic [32:0] d;
    d = {x[31], x} - {y[31], y};
    return d[32] ? (33'h0 - d) : d;
  endfunction

  // spike filter: a level is taken only after three equal samples
  function automatic logic aqe_filt(input logic [2:0] sh, input logic cur);
    return (&sh) ? 1'b1 : ((~|sh) ? 1'b0 : cur);
  endfunction

  // register read mux
  function automatic logic [32:0] aqe_read(input aqe_state_type s, input aqe_addr_type a);
    logic [32:0] r;
    r = 33'h0;
    unique case (a)
      `AQE_OFS_GLOBAL_CFG: r = {1'b0, 31'h0, s.pins_en};
      `AQE_OFS_MODE: r = {1'b0, 25'h0, s.mode};
      `AQE_OFS_POS: r = {1'b0, s.pos};
      `AQE_OFS_CONST: r = {1'b0, s.konst};
      `AQE_OFS_STATUS: r = {1'b0, 30'h0, s.stat};
      `AQE_OFS_LATCH: r = {1'b0, s.latch};
      `AQE_OFS_DEVLIM: r = {1'b0, s.dev_lim};
      `AQE_OFS_MASK: r = {1'b0, 30'h0, s.mask};
      default: r = {1'b1, 32'h0};
    endcase
    return r;
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    setup_ph = psel_in && !penable_in;
    wr_en = psel_in && penable_in && st_r.ready && pwrite_in && !st_r.slverr;

    st_nxt.sh_a = {st_r.sh_a[1:0], enc_a_in};
    st_nxt.sh_b = {st_r.sh_b[1:0], enc_b_in};
    st_nxt.sh_n = {st_r.sh_n[1:0], enc_n_in};
    st_nxt.flt_a = aqe_filt(st_r.sh_a, st_r.flt_a);
    st_nxt.flt_b = aqe_filt(st_r.sh_b, st_r.flt_b);
    st_nxt.flt_n = aqe_filt(st_r.sh_n, st_r.flt_n);
    st_nxt.prv_a = st_r.flt_a;
    st_nxt.prv_b = st_r.flt_b;
    st_nxt.prv_n = st_r.flt_n;

    // pins only count while selected as encoder inputs
    // direction from phase order, one channel changing at a time
    step_ev = st_r.pins_en && ((st_r.flt_a ^ st_r.prv_a) ^ (st_r.flt_b ^ st_r.prv_b));
    step_up = st_r.prv_a ^ st_r.flt_b;

    // null qualified by selected a and b levels
    n_edge = (st_r.flt_n == st_r.mode[`AQE_MODE_POL_N])
             && (st_r.prv_n != st_r.mode[`AQE_MODE_POL_N]);
    n_qual = (!st_r.mode[`AQE_MODE_POL_A] || st_r.flt_a)
             && (!st_r.mode[`AQE_MODE_POL_B] || st_r.flt_b);
    n_valid = st_r.pins_en && n_edge && n_qual;
    // armed by either option, idle otherwise
    n_armed = st_r.mode[`AQE_MODE_CLR_CONT] || st_r.mode[`AQE_MODE_CLR_ONCE];
    // clear only with clear flag and an option armed
    n_clear = n_valid && n_armed && st_r.mode[`AQE_MODE_CLR_ENC];
    n_latch = n_valid && n_armed && !st_r.mode[`AQE_MODE_CLR_ENC];

    stepped = aqe_step(st_r.pos, st_r.frac, st_r.konst, st_r.mode[`AQE_MODE_DEC], step_up);
    if (step_ev)
    begin
      st_nxt.pos = stepped[47:16];
      st_nxt.frac = stepped[15:0];
    end
    // clear wins over a simultaneous step
    if (n_clear)
    begin
      st_nxt.pos = 32'h0;
      st_nxt.frac = 16'h0;
    end
    if (n_latch)
    begin
      st_nxt.latch = st_r.pos;
    end
    if (n_valid && n_armed && st_r.mode[`AQE_MODE_CLR_ONCE])
    begin
      st_nxt.mode[`AQE_MODE_CLR_ONCE] = 1'b0;
    end

    dev_over = (st_r.dev_lim != 32'h0)
               && (aqe_absdiff(st_r.pos, motor_pos_in) > {1'b0, st_r.dev_lim});

    // register writes
    wr_pos = 1'b0;
    stat_clr = 2'h0;
    if (wr_en)
    begin
      unique case (paddr_in)
        `AQE_OFS_GLOBAL_CFG: st_nxt.pins_en = pwdata_in[0];
        `AQE_OFS_MODE: st_nxt.mode = pwdata_in[6:0];
        `AQE_OFS_POS: wr_pos = 1'b1;
        `AQE_OFS_CONST: st_nxt.konst = pwdata_in;
        `AQE_OFS_STATUS: stat_clr = pwdata_in[1:0];
        `AQE_OFS_DEVLIM: st_nxt.dev_lim = pwdata_in;
        `AQE_OFS_MASK: st_nxt.mask = pwdata_in[1:0];
        default: stat_clr = 2'h0;
      endcase
    end
    if (wr_pos)
    begin
      st_nxt.pos = pwdata_in;
      st_nxt.frac = 16'h0;
    end

    // sticky status, set wins over write-one-clear
    stat_set = 2'h0;
    stat_set[`AQE_ST_NCLR] = n_clear;
    stat_set[`AQE_ST_DEV] = dev_over;
    st_nxt.stat = (st_r.stat & ~stat_clr) | stat_set;
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

    // apb answer prepared in the setup phase
    st_nxt.ready = setup_ph;
    st_nxt.slverr = 1'b0;
    st_nxt.rdata = 32'h0;
    if (setup_ph)
    begin
      {st_nxt.slverr, st_nxt.rdata} = aqe_read(st_r, paddr_in);
      if (pwrite_in)
      begin
        st_nxt.rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
      st_r.pins_en <= `AQE_GLOBAL_CFG_RST;
      st_r.mode <= `AQE_MODE_RST;
      st_r.konst <= `AQE_CONST_RST;
      st_r.dev_lim <= `AQE_DEVLIM_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata_out = st_r.rdata;
  assign pready_out = st_r.ready;
  assign pslverr_out = st_r.slverr;
  assign enc_pins_sel_out = st_r.pins_en;
  assign irq_out = st_r.irq;

  // checks
  pins_gate_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (!st_r.pins_en && !wr_en) |=> ($stable(st_r.pos) && $stable(st_r.latch)))
    else $error("position moved while pins not selected");

  null_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (n_valid && !n_armed) |=> ($stable(st_r.latch) && !$rose(st_r.stat[`AQE_ST_NCLR])))
    else $error("unarmed null event had an effect");

  null_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (n_valid && n_armed && st_r.mode[`AQE_MODE_CLR_ENC] && !wr_en)
    |=> (st_r.pos == 32'h0 && st_r.frac == 16'h0))
    else $error("null event did not clear position");

  cont_keep_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (n_valid && st_r.mode[`AQE_MODE_CLR_CONT] && !wr_en)
    |=> st_r.mode[`AQE_MODE_CLR_CONT])
    else $error("continuous option lost after event");

  once_disarm_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (n_valid && st_r.mode[`AQE_MODE_CLR_ONCE] && !wr_en)
    |=> !st_r.mode[`AQE_MODE_CLR_ONCE])
    else $error("single option not disarmed");

  null_qual_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (n_valid && st_r.mode[`AQE_MODE_POL_A] && st_r.mode[`AQE_MODE_POL_B])
    |-> (st_r.flt_a && st_r.flt_b && $past(st_r.flt_n) != st_r.flt_n))
    else $error("null accepted without a and b high");

  bin_step_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (step_ev && step_up && !st_r.mode[`AQE_MODE_DEC] && !n_clear && !wr_en)
    |=> ({st_r.pos, st_r.frac}
         == $past({st_r.pos, st_r.frac}) + {{16{$past(st_r.konst[31])}}, $past(st_r.konst)}))
    else $error("binary step mismatch");

  dir_order_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (step_ev && !st_r.mode[`AQE_MODE_DEC] && !n_clear && !wr_en
     && st_r.prv_a == 1'b0 && st_r.prv_b == 1'b0 && st_r.flt_b)
    |=> ({st_r.pos, st_r.frac}
         == $past({st_r.pos, st_r.frac}) + {{16{$past(st_r.konst[31])}}, $past(st_r.konst)}))
    else $error("forward phase order did not count up");

  dec_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (st_r.mode[`AQE_MODE_DEC] && st_r.frac < 16'h2710 && st_r.konst[15:0] < 16'h2710
     && !wr_en && !wr_pos)
    |=> st_r.frac < 16'h2710)
    else $error("decimal fraction left range");

  filt_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $changed(st_r.flt_a)
    |-> ($past(enc_a_in, 2) == st_r.flt_a && $past(enc_a_in, 3) == st_r.flt_a
         && $past(enc_a_in, 4) == st_r.flt_a))
    else $error("filter passed a short pulse");

  latch_copy_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    n_latch |=> (st_r.latch == $past(st_r.pos)))
    else $error("latch did not capture position");

  clr_stat_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    n_clear |=> st_r.stat[`AQE_ST_NCLR])
    else $error("clear event not recorded");

  dev_irq_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (dev_over && st_r.mask[`AQE_ST_DEV] && !(wr_en && paddr_in == `AQE_OFS_MASK))
    |=> (st_r.stat[`AQE_ST_DEV] && irq_out))
    else $error("deviation did not raise interrupt");

  pos_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (setup_ph && !pwrite_in && paddr_in == `AQE_OFS_POS)
    |=> (pready_out && !pslverr_out && prdata_out == $past(st_r.pos)))
    else $error("position read wrong");

  ready_answer_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (psel_in && !penable_in) |=> pready_out)
    else $error("setup phase not answered");

  ready_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (pready_out && penable_in) |=> !pready_out)
    else $error("ready held too long");

  unmapped_err_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (psel_in && !penable_in && paddr_in > `AQE_OFS_MASK)
    |=> (pslverr_out && prdata_out == 32'h0))
    else $error("unmapped address not refused");

  pos_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_en && paddr_in == `AQE_OFS_POS)
    |=> (st_r.pos == $past(pwdata_in) && st_r.frac == 16'h0))
    else $error("position write lost");

  pins_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_en && paddr_in == `AQE_OFS_GLOBAL_CFG)
    |=> (enc_pins_sel_out == $past(pwdata_in[0])))
    else $error("pin selection write lost");

  irq_mirror_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    irq_out == |(st_r.stat & st_r.mask))
    else $error("interrupt level wrong");

  latch_no_stat_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    n_latch |=> !$rose(st_r.stat[`AQE_ST_NCLR]))
    else $error("latch event flagged as clear");

  clear_keep_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    n_clear |=> $stable(st_r.latch))
    else $error("clear event touched latch");

  down_step_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (step_ev && !step_up && !st_r.mode[`AQE_MODE_DEC] && !n_clear && !wr_en)
    |=> ({st_r.pos, st_r.frac}
         == $past({st_r.pos, st_r.frac}) - {{16{$past(st_r.konst[31])}}, $past(st_r.konst)}))
    else $error("binary down step mismatch");

  both_edge_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (st_r.flt_a != st_r.prv_a && st_r.flt_b != st_r.prv_b && !n_clear && !wr_en)
    |=> $stable(st_r.pos))
    else $error("double edge counted");

  dec_carry_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (step_ev && step_up && st_r.mode[`AQE_MODE_DEC] && !n_clear && !wr_en
     && st_r.frac < 16'h2710 && st_r.konst[15:0] < 16'h2710
     && (st_r.frac + st_r.konst[15:0]) >= 16'h2710)
    |=> (st_r.pos == $past(st_r.pos)
         + {{16{$past(st_r.konst[31])}}, $past(st_r.konst[31:16])} + 32'h1))
    else $error("decimal carry mismatch");

  filt_null_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $changed(st_r.flt_n)
    |-> ($past(enc_n_in, 2) == st_r.flt_n && $past(enc_n_in, 3) == st_r.flt_n
         && $past(enc_n_in, 4) == st_r.flt_n))
    else $error("null filter passed a short pulse");
endmodule

// >>> aqe_enc_model.sv
// incremental quadrature encoder model driving the a, b and null lines
module aqe_enc_model
(
  // clock
  input wire logic ref_clk_in,
  // encoder lines
  output logic enc_a_out,
  output logic enc_b_out,
  output logic enc_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph;
  initial
  begin
    ph = 2'h0;
    enc_a_out = 1'b0;
    enc_b_out = 1'b0;
    enc_n_out = 1'b0;
  end
  // one gray step, eight clocks per level
  task automatic step(input logic up);
    @(posedge ref_clk_in);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    enc_a_out <= ph[1];
    enc_b_out <= ph[1] ^ ph[0];
    repeat (7) @(posedge ref_clk_in);
  endtask
  // short pulse on a, two clocks wide
  task automatic spike();
    @(posedge ref_clk_in);
    enc_a_out <= ~enc_a_out;
    repeat (2) @(posedge ref_clk_in);
    enc_a_out <= ~enc_a_out;
    repeat (8) @(posedge ref_clk_in);
  endtask
  task automatic null_pulse();
    @(posedge ref_clk_in);
    enc_n_out <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    enc_n_out <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
  endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the quadrature encoder interface
`include "aqe_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import aqe_pkg::*;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  aqe_addr_type paddr;
  aqe_word_type pwdata;
  aqe_word_type motor_pos;
  aqe_word_type prdata;
  aqe_word_type rd;
  logic pready, pslverr, enc_a, enc_b, enc_n, pins_sel, irq;
  int fail_count = 0;
  int compares = 0;
  aqe_encoder dut_u
  (
    .ref_clk_in(clk),
    .rst_n_in(rst_n),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .paddr_in(paddr),
    .pwdata_in(pwdata),
    .prdata_out(prdata),
    .pready_out(pready),
    .pslverr_out(pslverr),
    .enc_a_in(enc_a),
    .enc_b_in(enc_b),
    .enc_n_in(enc_n),
    .motor_pos_in(motor_pos),
    .enc_pins_sel_out(pins_sel),
    .irq_out(irq)
  );
  aqe_enc_model enc_u
  (
    .ref_clk_in(clk),
    .enc_a_out(enc_a),
    .enc_b_out(enc_b),
    .enc_n_out(enc_n)
  );
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finish_test();
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input aqe_word_type got, input aqe_word_type exp);
    compares++;
    if (got !== exp)
    begin
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input aqe_addr_type a, input aqe_word_type d,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input aqe_addr_type a, input aqe_word_type d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task automatic rdc(input aqe_addr_type a, input aqe_word_type exp);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk(rd, exp);
  endtask
  task automatic t_regs();
    logic e;
    rdc(`AQE_OFS_GLOBAL_CFG, 32'h0);
    rdc(`AQE_OFS_MODE, 32'h4);
    rdc(`AQE_OFS_POS, 32'h0);
    rdc(`AQE_OFS_CONST, 32'h00010000);
    rdc(`AQE_OFS_STATUS, 32'h0);
    rdc(`AQE_OFS_DEVLIM, 32'h0);
    rdc(`AQE_OFS_MASK, 32'h0);
    wr(`AQE_OFS_LATCH, 32'h5);
    rdc(`AQE_OFS_LATCH, 32'h0);
    apb(1'b0, 12'h020, 32'h0, e);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_count();
    enc_u.step(1'b1);
    enc_u.step(1'b0);
    rdc(`AQE_OFS_POS, 32'h0);
    wr(`AQE_OFS_GLOBAL_CFG, 32'h1);
    @(posedge clk);
    chk({31'h0, pins_sel}, 32'h1);
    repeat (4) enc_u.step(1'b1);
    rdc(`AQE_OFS_POS, 32'h4);
    repeat (6) enc_u.step(1'b0);
    rdc(`AQE_OFS_POS, 32'hfffffffe);
    wr(`AQE_OFS_CONST, 32'hffff0000);
    repeat (3) enc_u.step(1'b1);
    rdc(`AQE_OFS_POS, 32'hfffffffb);
  endtask
  task automatic t_frac();
    wr(`AQE_OFS_CONST, 32'h00008000);
    wr(`AQE_OFS_POS, 32'h0);
    repeat (3) enc_u.step(1'b1);
    rdc(`AQE_OFS_POS, 32'h1);
    wr(`AQE_OFS_MODE, 32'h44);
    wr(`AQE_OFS_CONST, 32'h00001770);
    wr(`AQE_OFS_POS, 32'h0);
    repeat (2) enc_u.step(1'b1);
    rdc(`AQE_OFS_POS, 32'h1);
    wr(`AQE_OFS_CONST, 32'hffe60fa0);
    wr(`AQE_OFS_POS, 32'h0);
    repeat (2) enc_u.step(1'b1);
    rdc(`AQE_OFS_POS, 32'hffffffcc);
    wr(`AQE_OFS_MODE, 32'h4);
    wr(`AQE_OFS_CONST, 32'h00010000);
    wr(`AQE_OFS_POS, 32'h7);
    enc_u.spike();
    rdc(`AQE_OFS_POS, 32'h7);
  endtask
  task automatic t_null();
    wr(`AQE_OFS_MODE, 32'h24);
    enc_u.null_pulse();
    rdc(`AQE_OFS_POS, 32'h7);
    wr(`AQE_OFS_MODE, 32'h2c);
    wr(`AQE_OFS_MASK, 32'h1);
    enc_u.null_pulse();
    rdc(`AQE_OFS_POS, 32'h0);
    rdc(`AQE_OFS_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    enc_u.step(1'b1);
    enc_u.null_pulse();
    rdc(`AQE_OFS_POS, 32'h0);
    wr(`AQE_OFS_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(`AQE_OFS_STATUS, 32'h1);
    rdc(`AQE_OFS_STATUS, 32'h0);
    wr(`AQE_OFS_POS, 32'h9);
    wr(`AQE_OFS_MODE, 32'h14);
    enc_u.null_pulse();
    rdc(`AQE_OFS_LATCH, 32'h9);
    rdc(`AQE_OFS_MODE, 32'h4);
    rdc(`AQE_OFS_STATUS, 32'h0);
    enc_u.step(1'b1);
    enc_u.null_pulse();
    rdc(`AQE_OFS_LATCH, 32'h9);
  endtask
  task automatic t_qual();
    while (enc_u.ph !== 2'h0)
      enc_u.step(1'b1);
    wr(`AQE_OFS_POS, 32'h5);
    wr(`AQE_OFS_MODE, 32'h2f);
    enc_u.null_pulse();
    rdc(`AQE_OFS_POS, 32'h5);
    repeat (2) enc_u.step(1'b1);
    enc_u.null_pulse();
    rdc(`AQE_OFS_POS, 32'h0);
    wr(`AQE_OFS_POS, 32'h3);
    wr(`AQE_OFS_MODE, 32'h28);
    enc_u.null_pulse();
    rdc(`AQE_OFS_POS, 32'h0);
  endtask
  task automatic t_dev();
    @(posedge clk);
    motor_pos <= 32'hfffffffb;
    wr(`AQE_OFS_DEVLIM, 32'h5);
    wr(`AQE_OFS_MASK, 32'h2);
    wr(`AQE_OFS_STATUS, 32'h3);
    rdc(`AQE_OFS_STATUS, 32'h0);
    motor_pos <= 32'hfffffffa;
    repeat (3) @(posedge clk);
    rdc(`AQE_OFS_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    motor_pos <= 32'h0;
    wr(`AQE_OFS_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  initial
  begin
    rst_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h00000000;
    motor_pos <= 32'h00000000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_count();
    t_frac();
    t_null();
    t_qual();
    t_dev();
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule
